// ### hdl/tic_pkg.sv
package tic_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_CONV  = 8'h02; // conversion setting
	localparam logic [7:0] ADDR_CHSEL = 8'h0F; // channel selection
	localparam logic [7:0] ADDR_OFS0  = 8'h13; // offset value, low byte
	localparam logic [7:0] ADDR_GAIN0 = 8'h16; // gain value, low byte
	localparam logic [7:0] ADDR_START = 8'h1A; // module startup
	localparam logic [7:0] ADDR_INFO  = 8'h1B; // active conversion setting copy
	localparam logic [7:0] ADDR_STAT  = 8'h1C; // block status

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int unsigned NCH          = 4;      // input channels
	localparam int unsigned NENT         = 8;      // offset and gain per channel
	localparam int unsigned CONV_MODE_BIT = 0;     // operation mode
	localparam int unsigned CONV_CAL_BIT = 1;      // calibration select
	localparam logic [7:0]  CONV_RST     = 8'h00;  // conversion setting reset
	localparam logic [7:0]  CONV_MASK    = 8'h3F;  // top two bits reserved
	localparam logic [23:0] CAL_RST      = 24'h000000;
	localparam int unsigned CAL_SIGN_BIT = 23;     // sign of a correction value
	localparam int unsigned TMP_OVER_BIT = 23;     // out of range flag
	localparam int unsigned TMP_SIGN_BIT = 22;     // sign of a temperature
	localparam logic [21:0] TMP_MAG_MAX  = 22'h3FFFFF;

	// ****************************************
	// calibration points in hundredths of a degree
	// ****************************************
	localparam logic signed [47:0] LO_PT = -48'sh000000004E20;
	localparam logic signed [47:0] HI_PT = 48'sh000000014C08;
	localparam logic signed [47:0] SPAN  = HI_PT - LO_PT;

	// non-volatile controller states
	typedef enum logic [2:0] {
		ST_BOOT = 3'b001,
		ST_IDLE = 3'b010,
		ST_PROG = 3'b100
	} tic_nv_state_e;

	// sign-magnitude to two's complement
	function automatic logic signed [47:0] tic_sm_to_int(input logic sgn, input logic [22:0] mag);
		logic signed [47:0] v;
		v = signed'({25'h0, mag});
		return sgn ? -v : v;
	endfunction

	// byte lane of a three-byte field, with hit flag
	function automatic logic [2:0] tic_field(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] d;
		d = addr - base;
		return {(addr >= base) && (d < 8'h03), d[1:0]};
	endfunction

endpackage

// ### hdl/tic_nv_if.sv
interface tic_nv_if;
	import tic_pkg::*;
	logic        load_v;    // stored value read back at boot
	logic [2:0]  load_idx;
	logic [23:0] load_data;
	logic [7:0]  dirty;     // entries waiting for programming
	logic        clr_v;     // entry programmed
	logic [2:0]  clr_idx;
	logic [2:0]  prog_idx;  // entry picked for programming
	logic [23:0] prog_data;
	logic        boot_done;
	logic        busy;

	modport core (input load_v, load_idx, load_data, clr_v, clr_idx, prog_idx,
		boot_done, busy, output dirty, prog_data);
	modport ctrl (output load_v, load_idx, load_data, clr_v, clr_idx, prog_idx,
		boot_done, busy, input dirty, prog_data);
endinterface

// ### hdl/tic_nv_ctrl.sv
module tic_nv_ctrl
	import tic_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rst,
	tic_nv_if.ctrl     nv,
	output logic       nvm_req,
	output logic       nvm_we,
	output logic [2:0] nvm_addr,
	output logic [23:0] nvm_wdata,
	input  wire logic [23:0] nvm_rdata,
	input  wire logic  nvm_ack
);
	import tic_pkg::*;

	tic_nv_state_e state_q, state_d; // controller state
	logic [2:0]    idx_q, idx_d;     // entry in flight
	logic [23:0]   wdata_q, wdata_d; // value being programmed
	logic [2:0]    pick;             // lowest dirty entry

	// ****************************************
	// lowest waiting entry
	// ****************************************
	always_comb begin
		pick = 3'h0;
		for (int i = NENT - 1; i >= 0; i--) begin
			if (nv.dirty[i]) begin
				pick = 3'(i);
			end
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		wdata_d = wdata_q;
		unique case (state_q)
			ST_BOOT: begin // reload every entry once
				if (nvm_ack) begin
					idx_d = idx_q + 3'h1;
					if (idx_q == 3'h7) begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_IDLE: begin // wait for a changed value
				if (|nv.dirty) begin
					idx_d   = pick;
					wdata_d = nv.prog_data;
					state_d = ST_PROG;
				end
			end
			ST_PROG: begin // hold request until the store answers
				if (nvm_ack) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_BOOT;
			idx_q   <= 3'h0;
			wdata_q <= CAL_RST;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
			wdata_q <= wdata_d;
		end
	end

	// ****************************************
	// store port and core side
	// ****************************************
	assign nvm_req      = (state_q != ST_IDLE);
	assign nvm_we       = (state_q == ST_PROG);
	assign nvm_addr     = idx_q;
	assign nvm_wdata    = wdata_q;
	assign nv.load_v    = (state_q == ST_BOOT) && nvm_ack; // RULE4
	assign nv.load_idx  = idx_q;
	assign nv.load_data = nvm_rdata;
	assign nv.clr_v     = (state_q == ST_PROG) && nvm_ack; // RULE2
	assign nv.clr_idx   = idx_q;
	assign nv.prog_idx  = pick;
	assign nv.boot_done = (state_q != ST_BOOT);
	assign nv.busy      = (state_q == ST_PROG);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	prog_value_a: assert property ($rose(nvm_we) |-> nvm_wdata == $past(nv.prog_data)) // RULE2
		else $error("programmed value differs from picked entry");
endmodule

// ### hdl/tic_corrector.sv
module tic_corrector
	import tic_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        in_valid,
	input  wire logic [1:0]  in_ch,
	input  wire logic [23:0] in_data,
	input  wire logic        cal_on,
	input  wire logic [23:0] offset,
	input  wire logic [23:0] gain,
	output logic             out_valid,
	output logic [1:0]       out_ch,
	output logic [23:0]      out_data
);
	import tic_pkg::*;

	logic signed [47:0] x, o, g, e, y; // working values
	logic [47:0]        mag;            // corrected magnitude
	logic               sat;            // beyond the data field
	logic               valid_d;
	logic [1:0]         ch_d;
	logic [23:0]        data_d;

	// ****************************************
	// linear correction between two points
	// ****************************************
	always_comb begin
		x   = tic_sm_to_int(in_data[TMP_SIGN_BIT], {1'b0, in_data[21:0]}); // RULE7
		o   = tic_sm_to_int(offset[CAL_SIGN_BIT], offset[22:0]);
		g   = tic_sm_to_int(gain[CAL_SIGN_BIT], gain[22:0]);
		e   = o + ((g - o) * (x - LO_PT)) / SPAN; // RULE16
		y   = x - e;
		mag = (y < 0) ? 48'(-y) : 48'(y);
		sat = (mag > 48'(TMP_MAG_MAX));
		valid_d = in_valid;
		ch_d    = in_ch;
		if (cal_on) begin // RULE1
			data_d = {in_data[TMP_OVER_BIT] | sat, (y < 0), sat ? TMP_MAG_MAX : mag[21:0]};
		end else begin
			data_d = in_data;
		end
	end

	// result registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_ch    <= 2'h0;
			out_data  <= 24'h000000;
		end else begin
			out_valid <= valid_d;
			out_ch    <= ch_d;
			out_data  <= data_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	bypass_pass_a: assert property (in_valid && !cal_on |=> out_data == $past(in_data)) // RULE1
		else $error("uncorrected result altered");
	no_neg_zero_a: assert property ($past(cal_on) && out_valid && out_data[TMP_SIGN_BIT] // RULE7
		|-> out_data[21:0] != 22'h000000)
		else $error("negative zero produced");
endmodule

// ### hdl/tic_calib_regs.sv
// Overview of operation
// RULE1: correct results only while calibration bit set
// RULE2: each value write queued for non-volatile store; a rewrite during that entry's programming, before the answer, is lost
// RULE3: calibration bit volatile, cleared on reset
// RULE4: stored values reloaded automatically after reset
// RULE5: software limits value rewrites, store wears
// RULE6: three-byte values address selected channel
// RULE7: values are sign-magnitude, hundredths degree
// RULE8: software checks temperature mode before calibrating
// RULE9: conversion setting at 02h, documented fields
// RULE10: software writes offset first, gain second
// RULE11: value is measured minus true, times 100
// RULE12: software loads values before enabling calibration
// RULE13: offset and gain held per channel
// RULE14: startup copies settings into information register
// RULE15: module runs only after startup bit set
// RULE16: linear correction between low and high points
module tic_calib_regs
	import tic_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	input  wire logic        raw_valid,
	input  wire logic [1:0]  raw_ch,
	input  wire logic [23:0] raw_data,
	output logic             res_valid,
	output logic [1:0]       res_ch,
	output logic [23:0]      res_data,
	output logic             nvm_req,
	output logic             nvm_we,
	output logic [2:0]       nvm_addr,
	output logic [23:0]      nvm_wdata,
	input  wire logic [23:0] nvm_rdata,
	input  wire logic        nvm_ack
);
	import tic_pkg::*;

	// ****************************************
	// state
	// ****************************************
	logic [7:0]  conv_q, conv_d;     // conversion setting
	logic [1:0]  chsel_q, chsel_d;   // selected channel
	logic [15:0] stage_q, stage_d;   // low bytes awaiting the top byte
	logic        start_q, start_d;   // startup activation
	logic [7:0]  info_q, info_d;     // settings copy taken at start
	logic [7:0]  rdata_q, rdata_d;   // read data
	logic [7:0]  dirty_q, dirty_d;   // entries to program
	logic [23:0] cal_q [NENT];       // offset even, gain odd
	logic [23:0] cal_d [NENT];

	// ****************************************
	// decode
	// ****************************************
	logic [2:0]  ofs_f, gain_f;      // hit and byte lane
	logic        fld_hit;            // any value byte
	logic [1:0]  fld_lane;
	logic        commit;             // top byte written
	logic [2:0]  cidx;               // entry index of access
	logic [23:0] commit_val;
	logic [23:0] sel_val;            // entry under the selected channel
	logic [7:0]  sel_ofs_b0;         // low offset byte of that channel
	logic [7:0]  status;
	logic        cal_on_w;

	tic_nv_if nv ();

	// each value field is three lanes wide; lane 3 never hits
	assign ofs_f      = tic_field(reg_addr, ADDR_OFS0);
	assign gain_f     = tic_field(reg_addr, ADDR_GAIN0);
	assign fld_hit    = ofs_f[2] | gain_f[2];
	assign fld_lane   = ofs_f[2] ? ofs_f[1:0] : gain_f[1:0];

	// entry index: channel select on top, gain flag below
	assign cidx       = {chsel_q, gain_f[2]}; // RULE6

	// only the top lane stores, so a value never lands half written
	assign commit     = reg_wr && fld_hit && (fld_lane == 2'h2);
	assign commit_val = {reg_wdata, stage_q};

	// read views of the selected channel
	assign sel_val    = cal_q[cidx];
	assign sel_ofs_b0 = cal_q[{chsel_q, 1'b0}][7:0];

	// status: programming, boot done, running
	assign status     = {5'h00, nv.busy, nv.boot_done, start_q};

	// store side sees the picked entry and the marks
	assign nv.prog_data = cal_q[nv.prog_idx];
	assign nv.dirty   = dirty_q;

	// ****************************************
	// next values
	// ****************************************
	always_comb begin
		conv_d  = conv_q;
		chsel_d = chsel_q;
		stage_d = stage_q;
		start_d = start_q;
		info_d  = info_q;
		rdata_d = rdata_q;
		dirty_d = dirty_q;
		cal_d   = cal_q;

		// boot reload, unless software already wrote the entry;
		// a value written during boot must not be lost to the old copy
		if (nv.load_v && !dirty_q[nv.load_idx]) begin // RULE4
			cal_d[nv.load_idx] = nv.load_data;
		end

		// programmed entry done: the store answered for it
		if (nv.clr_v) begin
			dirty_d[nv.clr_idx] = 1'b0;
		end

		// register writes; lanes 0 and 1 share one stage,
		// so a lone top byte stores whatever was staged last
		if (reg_wr) begin
			if (reg_addr == ADDR_CONV) begin // RULE9
				conv_d = reg_wdata & CONV_MASK;
			end else if (reg_addr == ADDR_CHSEL) begin
				chsel_d = reg_wdata[1:0];
			end else if (reg_addr == ADDR_START) begin
				start_d = reg_wdata[0];
			end else if (fld_hit && (fld_lane == 2'h0)) begin
				stage_d[7:0] = reg_wdata;
			end else if (fld_hit && (fld_lane == 2'h1)) begin
				stage_d[15:8] = reg_wdata;
			end
		end

		// full value stored per channel, then queued; set wins over clear,
		// so a rewrite in the cycle the store answers for that entry is programmed again
		if (commit) begin // RULE13
			cal_d[cidx]   = commit_val;
			dirty_d[cidx] = 1'b1; // RULE2
		end

		// settings snapshot on activation, only on the 0 to 1 step;
		// a restart takes a fresh copy
		if (start_d && !start_q) begin // RULE14
			info_d = conv_q;
		end

		// register reads; data is registered and holds until the next read,
		// unmapped addresses read as zero
		if (reg_rd) begin
			if (reg_addr == ADDR_CONV) begin
				rdata_d = conv_q;
			end else if (reg_addr == ADDR_CHSEL) begin
				rdata_d = {6'h00, chsel_q};
			end else if (reg_addr == ADDR_START) begin
				rdata_d = {7'h00, start_q};
			end else if (reg_addr == ADDR_INFO) begin
				rdata_d = info_q;
			end else if (reg_addr == ADDR_STAT) begin
				rdata_d = status;
			end else if (fld_hit) begin // RULE6
				unique case (fld_lane)
					2'h0: begin
						rdata_d = sel_val[7:0];
					end
					2'h1: begin
						rdata_d = sel_val[15:8];
					end
					default: begin // lane 3 cannot hit
						rdata_d = sel_val[23:16];
					end
				endcase
			end else begin // unmapped reads zero
				rdata_d = 8'h00;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// synchronous reset; the cal bit is never kept, values wait for reload
	always_ff @(posedge core_clk) begin
		if (rst) begin
			conv_q  <= CONV_RST; // RULE3
			chsel_q <= 2'h0;
			stage_q <= 16'h0000;
			start_q <= 1'b0;
			info_q  <= CONV_RST;
			rdata_q <= 8'h00;
			dirty_q <= 8'h00;
			for (int i = 0; i < NENT; i++) begin
				cal_q[i] <= CAL_RST;
			end
		end else begin
			conv_q  <= conv_d;
			chsel_q <= chsel_d;
			stage_q <= stage_d;
			start_q <= start_d;
			info_q  <= info_d;
			rdata_q <= rdata_d;
			dirty_q <= dirty_d;
			cal_q   <= cal_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************
	// store controller and correction path
	// ****************************************
	// reads entries 0 to 7 after reset, then programs marked entries,
	// lowest first, one at a time
	tic_nv_ctrl u_nv (
		.core_clk  (core_clk),
		.rst       (rst),
		.nv        (nv.ctrl),
		.nvm_req   (nvm_req),
		.nvm_we    (nvm_we),
		.nvm_addr  (nvm_addr),
		.nvm_wdata (nvm_wdata),
		.nvm_rdata (nvm_rdata),
		.nvm_ack   (nvm_ack)
	);

	// the cal bit acts at once, not through the start-time copy
	assign cal_on_w = conv_q[CONV_CAL_BIT]; // RULE1

	// offset and gain follow the channel of the incoming result;
	// no valid result enters the correction path until the module is started
	tic_corrector u_corr (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (raw_valid && start_q), // RULE15
		.in_ch     (raw_ch),
		.in_data   (raw_data),
		.cal_on    (cal_on_w),
		.offset    (cal_q[{raw_ch, 1'b0}]),
		.gain      (cal_q[{raw_ch, 1'b1}]),
		.out_valid (res_valid),
		.out_ch    (res_ch),
		.out_data  (res_data)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// the cal bit must come back cleared from every reset
	cal_bit_reset_a: assert property ($past(rst) |-> !conv_q[CONV_CAL_BIT]) // RULE3
		else $error("calibration bit survived reset");

	// reserved bits of the conversion setting never hold a one
	conv_rsvd_a: assert property (conv_q[7:6] == 2'h0) // RULE9
		else $error("reserved conversion bits set");

	// a conversion setting write lands with the reserved bits dropped
	conv_write_a: assert property (reg_wr && reg_addr == ADDR_CONV // RULE9
		|=> conv_q == ($past(reg_wdata) & CONV_MASK))
		else $error("conversion setting write lost");

	// every committed value is marked for the store
	nv_queue_a: assert property (commit |=> dirty_q[$past(cidx)]) // RULE2
		else $error("written value not queued for store");

	// a programmed entry loses its mark unless rewritten in that cycle
	clr_mark_a: assert property (nv.clr_v && !(commit && cidx == nv.clr_idx) // RULE2
		|=> !dirty_q[$past(nv.clr_idx)])
		else $error("programmed entry still marked");

	// a committed value lands in the entry of its own channel
	chan_write_a: assert property (commit |=> cal_q[$past(cidx)] == $past(commit_val)) // RULE13
		else $error("value not held for its channel");

	// reads of the offset low lane come from the selected channel
	sel_read_a: assert property (reg_rd && reg_addr == ADDR_OFS0 // RULE6
		|=> reg_rdata == $past(sel_ofs_b0))
		else $error("read not from selected channel");

	// start 0 to 1 copies the conversion setting
	info_copy_a: assert property ($rose(start_q) |-> info_q == $past(conv_q)) // RULE14
		else $error("settings not copied at start");

	// the copy is left alone outside activation
	info_hold_a: assert property (!(start_d && !start_q) // RULE14
		|=> info_q == $past(info_q))
		else $error("settings copy changed outside start");

	// a result only follows a started, valid input
	run_gate_a: assert property (res_valid |-> $past(start_q) && $past(raw_valid)) // RULE15
		else $error("result while module stopped");

	// nothing comes out while the module is stopped
	stop_quiet_a: assert property (!start_q |=> !res_valid) // RULE15
		else $error("result while stopped");

	// boot reads only; programming waits for the reload
	boot_no_prog_a: assert property (!nv.boot_done |-> !nvm_we) // RULE4
		else $error("store programmed during reload");

	// a stored value reaches the entry it belongs to
	reload_a: assert property (nv.load_v && !dirty_q[nv.load_idx] && !commit // RULE4
		|=> cal_q[$past(nv.load_idx)] == $past(nv.load_data))
		else $error("stored value not reloaded");
endmodule

// ### tb/tic_nv_store_model.sv
// ****************************************
// non-volatile store seen from the block
// ****************************************
module tic_nv_store_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        nvm_req,
	input  wire logic        nvm_we,
	input  wire logic [2:0]  nvm_addr,
	input  wire logic [23:0] nvm_wdata,
	output logic [23:0]      nvm_rdata,
	output logic             nvm_ack
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [23:0] mem [8];  // stored entries, survive reset
	logic [2:0]  wait_q;   // cycles spent on this request
	logic [1:0]  pace_q;   // answer delay, varies per transfer

	// ****************************************
	// contents before the first power-up
	// ****************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			mem[i] = 24'h000100 + 24'(i);
		end
		nvm_rdata = 24'h5A5A5A;
		nvm_ack   = 1'b0;
		wait_q    = 3'h0;
		pace_q    = 2'h0;
	end

	// answer each request after 1 to 4 cycles
	always @(posedge core_clk) begin
		if (rst) begin
			nvm_ack   <= 1'b0;
			nvm_rdata <= ~nvm_rdata;
			wait_q    <= 3'h0;
		end else if (nvm_req && !nvm_ack && (wait_q == {1'b0, pace_q})) begin
			nvm_ack <= 1'b1;
			wait_q  <= 3'h0;
			pace_q  <= pace_q + 2'h1;
			if (nvm_we) begin
				mem[nvm_addr] <= nvm_wdata;
				nvm_rdata     <= ~nvm_rdata;
			end else begin
				nvm_rdata <= mem[nvm_addr];
			end
		end else begin
			nvm_ack   <= 1'b0;
			nvm_rdata <= ~nvm_rdata; // no stale data outside an answer
			if (nvm_req && !nvm_ack) begin
				wait_q <= wait_q + 3'h1;
			end
		end
	end
endmodule

// ### tb/tic_calib_regs_tb.sv
module tic_calib_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import tic_pkg::*;

	logic        core_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        raw_valid;
	logic [1:0]  raw_ch;
	logic [23:0] raw_data;
	logic        res_valid;
	logic [1:0]  res_ch;
	logic [23:0] res_data;
	logic        nvm_req;
	logic        nvm_we;
	logic [2:0]  nvm_addr;
	logic [23:0] nvm_wdata;
	logic [23:0] nvm_rdata;
	logic        nvm_ack;
	int          errors;
	int          samples_checked;
	logic [23:0] v;

	tic_calib_regs i_tic_calib_regs (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.raw_valid(raw_valid), .raw_ch(raw_ch), .raw_data(raw_data), .res_valid(res_valid),
		.res_ch(res_ch), .res_data(res_data), .nvm_req(nvm_req), .nvm_we(nvm_we),
		.nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));

	tic_nv_store_model i_tic_nv_store_model (.core_clk(core_clk), .rst(rst), .nvm_req(nvm_req),
		.nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
		.nvm_ack(nvm_ack));

	// ****************************************
	// clock and helpers
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// compare and count
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one register byte write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// one register byte read, data the cycle after
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// three-byte value, low lane first, top lane commits
	task automatic wr24(input logic [7:0] base, input logic [23:0] d);
		for (int i = 0; i < 3; i++) begin
			wr(base + 8'(i), d[8*i +: 8]);
		end
	endtask

	task automatic rd24(input logic [7:0] base, output logic [23:0] d);
		logic [7:0] b;
		for (int i = 0; i < 3; i++) begin
			rd(base + 8'(i), b);
			d[8*i +: 8] = b;
		end
	endtask

	// poll boot reload done in status
	task automatic wait_boot();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 200 && s[1] !== 1'b1; i++) begin
			rd(ADDR_STAT, s);
		end
		chk("boot_done", 24'h000001, {23'h0, s[1]});
	endtask

	// one raw result and the answer a cycle later
	task automatic conv(input logic [1:0] ch, input logic [23:0] x, input logic vld,
		input logic [23:0] y);
		@(posedge core_clk);
		raw_valid <= 1'b1;
		raw_ch    <= ch;
		raw_data  <= x;
		@(posedge core_clk);
		raw_valid <= 1'b0;
		#1 chk("res_valid", {23'h0, vld}, {23'h0, res_valid});
		if (vld) begin
			chk("res_data", y, res_data);
			chk("res_ch", {22'h0, ch}, {22'h0, res_ch});
		end
	endtask

	task automatic stop_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		#40000;
		errors++;
		stop_test();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		errors = 0;
		samples_checked = 0;
		rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{raw_valid, raw_ch, raw_data} = '0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		wait_boot();
		rd(ADDR_CONV, v[7:0]);
		chk("conv_reset", 24'h000000, {16'h0, v[7:0]});
		rd24(ADDR_OFS0, v);
		chk("boot_ofs_ch0", 24'h000100, v);
		rd24(ADDR_GAIN0, v);
		chk("boot_gain_ch0", 24'h000101, v);
		// reserved bits dropped, temperature mode kept
		wr(ADDR_CONV, 8'hFC);
		rd(ADDR_CONV, v[7:0]);
		chk("conv_rw", 24'h00003C, {16'h0, v[7:0]});
		wr(ADDR_CHSEL, 8'h02);
		// measured minus true, times 100: -20 low, +200 high; each written once
		wr24(ADDR_OFS0, 24'h800014);
		wr24(ADDR_GAIN0, 24'h0000C8);
		rd24(ADDR_OFS0, v);
		chk("ofs_ch2", 24'h800014, v);
		rd24(ADDR_GAIN0, v);
		chk("gain_ch2", 24'h0000C8, v);
		wr(ADDR_CHSEL, 8'h00);
		rd24(ADDR_OFS0, v);
		chk("ofs_ch0_kept", 24'h000100, v);
		// both entries of channel 2 reach the store
		for (int i = 0; i < 100 && i_tic_nv_store_model.mem[5] !== 24'h0000C8; i++) begin
			@(posedge core_clk);
		end
		chk("store_ofs", 24'h800014, i_tic_nv_store_model.mem[4]);
		chk("store_gain", 24'h0000C8, i_tic_nv_store_model.mem[5]);
		// not started: results ignored
		conv(2'd2, 24'h404E20, 1'b0, 24'h0);
		wr(ADDR_START, 8'h01);
		rd(ADDR_INFO, v[7:0]);
		chk("info_copy", 24'h00003C, {16'h0, v[7:0]});
		rd(ADDR_STAT, v[7:0]);
		chk("status_run", 24'h000003, {16'h0, v[7:0]});
		conv(2'd2, 24'h404E20, 1'b1, 24'h404E20);
		// values loaded and temperature mode confirmed before enabling
		rd(ADDR_CONV, v[7:0]);
		chk("temp_mode", 24'h000000, {23'h0, v[CONV_MODE_BIT]});
		wr(ADDR_CONV, 8'h3E);
		conv(2'd2, 24'h404E20, 1'b1, 24'h404E0C);
		conv(2'd2, 24'h014C08, 1'b1, 24'h014B40);
		conv(2'd0, 24'h404E20, 1'b1, 24'h404F20);
		// second reset: cal bit lost, values reloaded
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		wait_boot();
		rd(ADDR_CONV, v[7:0]);
		chk("conv_rerst", 24'h000000, {16'h0, v[7:0]});
		wr(ADDR_CHSEL, 8'h02);
		rd24(ADDR_OFS0, v);
		chk("reload_ofs", 24'h800014, v);
		stop_test();
	end
endmodule
